/* File: hdl/nor_flash_host.sv */
// Host controller that drives a parallel NOR flash through its pins
`timescale 1ns/1ps
module nor_flash_host #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16,
  parameter longint TIMEOUT_CYC =
    nor_host_pkg::ARRAY_ERASE_DURATION_S * 2 * nor_host_pkg::CYC_PER_S
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User request port
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [2:0] reqOp,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic rspTimeout,
  // Flash pins
  output logic flashCe_n,
  output logic flashOe_n,
  output logic flashWe_n,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [DATA_W-1:0] flashDqIn
);
  initial begin
    if (ADDR_W < 12 || DATA_W < 8) $error("Address or data width too small");
  end

  typedef enum {IDLE, WR_LOW, WR_HIGH, RD_LOW, RD_DONE, POLL_HIGH, DONE} state_e;
  state_e state_r, stateNxt;

  logic [DATA_W-1:0] dqSync1_r, dqSync2_r;
  logic [2:0] op_r;
  logic [ADDR_W-1:0] userAddr_r;
  logic [DATA_W-1:0] userData_r;
  logic [2:0] step_r, stepNxt;
  logic [7:0] tick_r, tickNxt;
  logic [63:0] busy_r;
  logic havePrev_r, prevBit_r, polling_r;
  logic [DATA_W-1:0] rspData_r;
  logic rspTimeout_r;

  // Command sequence table: step count and per-step address and data
  logic [2:0] seqLen;
  logic [ADDR_W-1:0] seqAddr;
  logic [7:0] seqData;
  logic seqPoll;
  logic tickDone;
  logic lastStep;
  logic newBit;
  logic timedOut;

  assign seqLen = (op_r == nor_host_pkg::OP_PROGRAM) ? 3'd4 :
    (op_r == nor_host_pkg::OP_SECTOR_ERASE || op_r == nor_host_pkg::OP_ARRAY_ERASE) ? 3'd6 :
    (op_r == nor_host_pkg::OP_ID_READ) ? 3'd3 :
    (op_r == nor_host_pkg::OP_ID_EXIT) ? 3'd1 : 3'd0;
  assign seqPoll = op_r == nor_host_pkg::OP_PROGRAM || op_r == nor_host_pkg::OP_SECTOR_ERASE ||
    op_r == nor_host_pkg::OP_ARRAY_ERASE;
  // sector erase and program final write
  assign seqAddr = (step_r == seqLen - 3'd1 && op_r == nor_host_pkg::OP_SECTOR_ERASE) ?
      userAddr_r :
    (step_r == seqLen - 3'd1 && op_r == nor_host_pkg::OP_PROGRAM) ? userAddr_r :
    (op_r == nor_host_pkg::OP_ID_EXIT) ? userAddr_r :
    (step_r == 3'd1 || step_r == 3'd4) ?
      ADDR_W'(nor_host_pkg::ADDR_UNLOCK2) : ADDR_W'(nor_host_pkg::ADDR_UNLOCK1);
  assign seqData = (op_r == nor_host_pkg::OP_ID_EXIT) ? nor_host_pkg::CMD_ID_EXIT :
    (step_r == 3'd0 || step_r == 3'd3) ? nor_host_pkg::CMD_UNLOCK1 :
    (step_r == 3'd1 || step_r == 3'd4) ? nor_host_pkg::CMD_UNLOCK2 :
    (step_r == 3'd2 && op_r == nor_host_pkg::OP_PROGRAM) ? nor_host_pkg::CMD_PROGRAM :
    (step_r == 3'd2 && op_r == nor_host_pkg::OP_ID_READ) ? nor_host_pkg::CMD_ID_ENTRY :
    (step_r == 3'd2) ? nor_host_pkg::CMD_ERASE_SETUP :
    (op_r == nor_host_pkg::OP_ARRAY_ERASE) ? nor_host_pkg::CMD_ARRAY_ERASE :
    (op_r == nor_host_pkg::OP_SECTOR_ERASE) ? nor_host_pkg::CMD_SECTOR_ERASE :
    userData_r[7:0];
  assign lastStep = step_r == seqLen - 3'd1;
  assign newBit = dqSync2_r[nor_host_pkg::TOGGLE_BIT];
  assign timedOut = busy_r >= TIMEOUT_CYC;

  // Next state
  always_comb begin
    stateNxt = state_r;
    stepNxt = step_r;
    tickNxt = tick_r + 8'd1;
    case (state_r)
      IDLE: begin
        tickNxt = 8'd0;
        stepNxt = 3'd0;
        if (reqValid) stateNxt = (reqOp == nor_host_pkg::OP_READ) ? RD_LOW :
          (reqOp == nor_host_pkg::OP_ID_EXIT || reqOp <= nor_host_pkg::OP_ID_READ) ?
            WR_LOW : DONE;
      end
      WR_LOW: if (tick_r + 8'd1 >= 8'(nor_host_pkg::WRITE_PULSE_CYC)) begin
        stateNxt = WR_HIGH;
        tickNxt = 8'd0;
      end
      WR_HIGH: if (tick_r + 8'd1 >= 8'(nor_host_pkg::WRITE_HIGH_CYC)) begin
        tickNxt = 8'd0;
        if (!lastStep) begin
          stepNxt = step_r + 3'd1;
          stateNxt = WR_LOW;
        end else if (seqPoll || op_r == nor_host_pkg::OP_ID_READ) begin
          stateNxt = RD_LOW;
        end else begin
          stateNxt = DONE;
        end
      end
      // Two extra cycles cover the input synchroniser
      RD_LOW: if (tick_r + 8'd1 >= 8'(nor_host_pkg::READ_ACCESS_CYC + 2)) begin
        stateNxt = RD_DONE;
        tickNxt = 8'd0;
      end
      RD_DONE: begin
        tickNxt = 8'd0;
        if (polling_r && !(havePrev_r && newBit == prevBit_r) && !timedOut) stateNxt = POLL_HIGH;
        else stateNxt = DONE;
      end
      // toggled inputs held high between reads
      POLL_HIGH: if (tick_r + 8'd1 >= 8'(nor_host_pkg::POLL_HIGH_CYC)) begin
        stateNxt = RD_LOW;
        tickNxt = 8'd0;
      end
      DONE: stateNxt = IDLE;
      default: stateNxt = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      step_r <= 3'd0;
      tick_r <= 8'd0;
    end else begin
      state_r <= stateNxt;
      step_r <= stepNxt;
      tick_r <= tickNxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqSync1_r <= '0;
      dqSync2_r <= '0;
    end else begin
      dqSync1_r <= flashDqIn;
      dqSync2_r <= dqSync1_r;
    end
  end

  // Request capture; polling address held for the whole operation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= nor_host_pkg::OP_READ;
      userAddr_r <= '0;
      userData_r <= '0;
    end else if (state_r == IDLE && reqValid) begin
      op_r <= reqOp;
      userAddr_r <= reqAddr;
      userData_r <= reqData;
    end
  end

  // first read only records the level; long wait allowed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      havePrev_r <= 1'b0;
      prevBit_r <= 1'b0;
      polling_r <= 1'b0;
      busy_r <= '0;
    end else if (state_r == IDLE) begin
      havePrev_r <= 1'b0;
      polling_r <= reqValid && reqOp >= nor_host_pkg::OP_PROGRAM &&
        reqOp <= nor_host_pkg::OP_ARRAY_ERASE;
      busy_r <= '0;
    end else begin
      busy_r <= busy_r + 64'd1;
      if (state_r == RD_DONE) begin
        havePrev_r <= 1'b1;
        prevBit_r <= newBit;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspData_r <= '0;
      rspTimeout_r <= 1'b0;
    end else if (state_r == RD_DONE) begin
      rspData_r <= dqSync2_r;
      rspTimeout_r <= polling_r && timedOut;
    end else if (state_r == IDLE) begin
      rspTimeout_r <= 1'b0;
    end
  end

  // each poll read pulses select and output enable together
  assign flashCe_n = !(state_r == WR_LOW || state_r == RD_LOW);
  assign flashOe_n = state_r != RD_LOW;
  assign flashWe_n = state_r != WR_LOW;
  assign flashDqOe = state_r == WR_LOW || state_r == WR_HIGH;
  // same address for every status read; id read uses bit 0
  assign flashAddr = (state_r == WR_LOW || state_r == WR_HIGH) ? seqAddr :
    (op_r == nor_host_pkg::OP_ID_READ) ?
      (ADDR_W'(userAddr_r[nor_host_pkg::ID_SELECT_ADDR_BIT]) << nor_host_pkg::ID_SELECT_ADDR_BIT) :
      userAddr_r;
  assign flashDqOut = (lastStep && op_r == nor_host_pkg::OP_PROGRAM) ? userData_r :
    DATA_W'(seqData);
  assign reqReady = state_r == IDLE;
  assign rspValid = state_r == DONE;
  assign rspData = rspData_r;
  assign rspTimeout = rspTimeout_r;

  // Helper count of cycles with output enable high, saturating
  logic [7:0] oeHighCnt_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) oeHighCnt_r <= 8'h00;
    else if (!flashOe_n) oeHighCnt_r <= 8'h00;
    else if (oeHighCnt_r != 8'hFF) oeHighCnt_r <= oeHighCnt_r + 8'h01;
  end

  // write strobe and output enable never low together
  we_oe_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!flashWe_n && !flashOe_n)) else $error("Output enable low during write");
  poll_high_min_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(flashOe_n) && polling_r |-> oeHighCnt_r >= 8'(nor_host_pkg::POLL_HIGH_CYC))
    else $error("Poll high pulse too short");
  array_erase_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flashWe_n && lastStep && op_r == nor_host_pkg::OP_ARRAY_ERASE |->
      flashAddr == ADDR_W'(nor_host_pkg::ADDR_UNLOCK1) &&
      flashDqOut[7:0] == nor_host_pkg::CMD_ARRAY_ERASE)
    else $error("Array erase final write wrong");
  sector_erase_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flashWe_n && lastStep && op_r == nor_host_pkg::OP_SECTOR_ERASE |->
      flashAddr == userAddr_r && flashDqOut[7:0] == nor_host_pkg::CMD_SECTOR_ERASE)
    else $error("Sector erase final write wrong");
  poll_addr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == POLL_HIGH && $past(state_r) == POLL_HIGH |-> $stable(flashAddr))
    else $error("Poll address moved");
  poll_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == RD_DONE && havePrev_r && newBit == prevBit_r |=> state_r == DONE)
    else $error("Polling went on after equal reads");
endmodule

/* File: hdl/nor_host_pkg.sv */
// Constants for the NOR flash host controller
package nor_host_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Bus timing in ns
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_HIGH_NS = 35;
  localparam int READ_ACCESS_NS = 70;
  localparam int POLL_HIGH_PULSE_MIN_NS = 50;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POLL_HIGH_CYC =
    (POLL_HIGH_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest embedded operation times, in microseconds and seconds
  localparam int WORD_PROGRAM_DURATION_US = 200;
  localparam int DUAL_PROGRAM_DURATION_US = 100;
  localparam int SMALL_SECTOR_ERASE_DURATION_S = 3;
  localparam int LARGE_SECTOR_ERASE_DURATION_S = 5;
  localparam int ARRAY_ERASE_DURATION_S = 50;
  localparam longint CYC_PER_US = 1000000 / CLK_PERIOD_PS;
  localparam longint CYC_PER_S = 64'd1000000000000 / CLK_PERIOD_PS;
  // Command codes (low byte only is decoded by the device)
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
  localparam logic [7:0] CMD_ARRAY_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam int TOGGLE_BIT = 6;
  localparam int ID_SELECT_ADDR_BIT = 0;
  // Operation codes on the user port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_ARRAY_ERASE = 3'h3;
  localparam logic [2:0] OP_ID_READ = 3'h4;
  localparam logic [2:0] OP_ID_EXIT = 3'h5;
endpackage

/* File: tb/flash_model.sv */
// Behavioural NOR flash device facing the host controller pins
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h00A7 // Arbitrary value
) (
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] dqOut,
  // Test control
  input wire integer busyReads,
  output int addrFaults
);
  logic [15:0] mem [logic [20:0]];
  logic [2:0] step = 3'h0;
  logic idMode = 1'b0;
  logic wrOpen = 1'b0;
  logic toggleBit = 1'b1;
  logic pollNew = 1'b0;
  logic [15:0] curVal = 16'h0000;
  logic [20:0] pollAddr = 21'h000000;
  int busyLeft = 0;
  wire logic [7:0] cmd = dq[7:0];
  wire logic at555 = addr[11:0] == nor_host_pkg::ADDR_UNLOCK1;
  wire logic unlock1 = at555 && cmd == nor_host_pkg::CMD_UNLOCK1;
  wire logic unlock2 = addr[11:0] == nor_host_pkg::ADDR_UNLOCK2 && cmd == nor_host_pkg::CMD_UNLOCK2;
  wire logic rdStrobe = !ce_n && !oe_n && we_n;
  wire logic wrStrobe = !ce_n && !we_n;
  // Released bus shows the inverse of the last word
  assign dqOut = rdStrobe ? curVal : ~curVal;
  initial addrFaults = 0;
  always @(posedge rdStrobe) begin
    // Let the address settle after the launching edge
    #1;
    if (busyLeft > 0) begin
      if (!pollNew && addr != pollAddr) addrFaults++;
      pollNew = 1'b0;
      pollAddr = addr;
      toggleBit = ~toggleBit;
      curVal = {9'h000, toggleBit, 6'h00};
      busyLeft--;
    end else if (idMode && addr[20:1] == 20'h00000) begin
      curVal = addr[0] ? DEVICE_ID : MAKER_ID;
    end else begin
      curVal = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    end
  end
  always @(posedge wrStrobe) wrOpen = 1'b1;
  // Write lands when select or strobe rises, whichever comes first
  always @(negedge wrStrobe) begin
    if (wrOpen) begin
      wrOpen = 1'b0;
      if (step == 3'h3) begin
        mem[addr] = dq & (mem.exists(addr) ? mem[addr] : 16'hFFFF);
        busyLeft = busyReads;
        pollNew = 1'b1;
        step = 3'h0;
      end else if (cmd == nor_host_pkg::CMD_ID_EXIT) begin
        idMode = 1'b0;
        step = 3'h0;
      end else if (step == 3'h0 || step == 3'h4) begin
        step = unlock1 ? step + 3'h1 : 3'h0;
      end else if (step == 3'h1 || step == 3'h5) begin
        step = unlock2 ? step + 3'h1 : 3'h0;
      end else if (step == 3'h2) begin
        if (at555 && cmd == nor_host_pkg::CMD_ID_ENTRY) idMode = 1'b1;
        step = !at555 ? 3'h0 : cmd == nor_host_pkg::CMD_PROGRAM ? 3'h3 :
          cmd == nor_host_pkg::CMD_ERASE_SETUP ? 3'h4 : 3'h0;
      end else begin
        if (at555 && cmd == nor_host_pkg::CMD_ARRAY_ERASE) foreach (mem[k]) mem[k] = 16'hFFFF;
        if (cmd == nor_host_pkg::CMD_SECTOR_ERASE)
          foreach (mem[k]) if (k[20:15] == addr[20:15]) mem[k] = 16'hFFFF;
        busyLeft = busyReads;
        pollNew = 1'b1;
        step = 3'h0;
      end
    end
  end
endmodule

/* File: tb/test_nor_flash_host.sv */
// Self-checking bench for the NOR flash host controller
`timescale 1ns/1ps
module test_nor_flash_host;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqReady, rspValid, rspTimeout, flashCe_n, flashOe_n, flashWe_n, flashDqOe, gotTo;
  logic [2:0] reqOp = 3'h0;
  logic [20:0] reqAddr = 21'h000000;
  logic [20:0] flashAddr;
  logic [15:0] reqData = 16'h0000;
  logic [15:0] rspData, flashDqOut, flashDqIn, modelDq, gotData;
  int busyReads = 0;
  int addrFaults, error_cnt = 0, cmp_count = 0, oeHigh = 0;
  logic pollOp = 1'b0;
  assign flashDqIn = flashDqOe ? flashDqOut : modelDq;
  nor_flash_host #(.TIMEOUT_CYC(2000)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .rspTimeout(rspTimeout),
    .flashCe_n(flashCe_n), .flashOe_n(flashOe_n), .flashWe_n(flashWe_n),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn));
  flash_model i_flash (.ce_n(flashCe_n), .oe_n(flashOe_n), .we_n(flashWe_n),
    .addr(flashAddr), .dq(flashDqOut), .dqOut(modelDq), .busyReads(busyReads),
    .addrFaults(addrFaults));
  always #2.5 ref_clk = ~ref_clk;
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic doOp(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d,
                      input int busy);
    int n;
    @(posedge ref_clk);
    pollOp = op >= nor_host_pkg::OP_PROGRAM && op <= nor_host_pkg::OP_ARRAY_ERASE;
    busyReads <= busy;
    reqValid <= 1'b1;
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    #1;
    for (n = 0; reqReady !== 1'b1; n++) begin
      if (n > 20) begin
        check("reqReady", 16'h0001, 16'h0000);
        report_and_stop();
      end
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    reqValid <= 1'b0;
    #1;
    for (n = 0; rspValid !== 1'b1; n++) begin
      if (n > 5000) begin
        check("rspValid", 16'h0001, 16'h0000);
        report_and_stop();
      end
      @(posedge ref_clk);
      #1;
    end
    gotData = rspData;
    gotTo = rspTimeout;
  endtask
  // Write strobes never overlap an output enable, polls keep the high gap
  always @(posedge ref_clk) begin
    if (flashWe_n === 1'b0 && flashCe_n === 1'b0) check("oe in write", 16'h0001, {15'h0000, flashOe_n});
    if (flashOe_n === 1'b1) oeHigh <= oeHigh + 1;
    else begin
      if (pollOp && oeHigh != 0 && oeHigh < nor_host_pkg::POLL_HIGH_CYC)
        check("oe high gap", 16'(nor_host_pkg::POLL_HIGH_CYC), 16'(oeHigh));
      oeHigh <= 0;
    end
  end
  task automatic testId();
    doOp(nor_host_pkg::OP_READ, 21'h000000, 16'h0000, 0);
    check("read before id", 16'hFFFF, gotData);
    doOp(nor_host_pkg::OP_ID_READ, 21'h000000, 16'h0000, 0);
    check("maker code", 16'h005A, gotData);
    doOp(nor_host_pkg::OP_ID_READ, 21'h000001, 16'h0000, 0);
    check("device code", 16'h00A7, gotData);
    doOp(nor_host_pkg::OP_ID_EXIT, 21'h000ABC, 16'h0000, 0);
    doOp(nor_host_pkg::OP_READ, 21'h000000, 16'h0000, 0);
    check("read after exit", 16'hFFFF, gotData);
    $display("test id done");
  endtask
  task automatic testProgram();
    doOp(nor_host_pkg::OP_PROGRAM, 21'h000123, 16'hA5C3, 3);
    check("program timeout", 16'h0000, {15'h0000, gotTo});
    doOp(nor_host_pkg::OP_READ, 21'h000123, 16'h0000, 0);
    check("program data", 16'hA5C3, gotData);
    $display("test program done");
  endtask
  task automatic testErase();
    doOp(nor_host_pkg::OP_PROGRAM, 21'h008001, 16'h1234, 1);
    doOp(nor_host_pkg::OP_PROGRAM, 21'h010002, 16'h5678, 1);
    doOp(nor_host_pkg::OP_SECTOR_ERASE, 21'h008010, 16'h0000, 20);
    check("sector erase timeout", 16'h0000, {15'h0000, gotTo});
    doOp(nor_host_pkg::OP_READ, 21'h008001, 16'h0000, 0);
    check("erased sector", 16'hFFFF, gotData);
    doOp(nor_host_pkg::OP_READ, 21'h010002, 16'h0000, 0);
    check("other sector", 16'h5678, gotData);
    doOp(nor_host_pkg::OP_ARRAY_ERASE, 21'h000000, 16'h0000, 50);
    check("array erase timeout", 16'h0000, {15'h0000, gotTo});
    doOp(nor_host_pkg::OP_READ, 21'h010002, 16'h0000, 0);
    check("array erased", 16'hFFFF, gotData);
    check("poll address moves", 16'h0000, 16'(addrFaults));
    $display("test erase done");
  endtask
  task automatic testTimeout();
    doOp(nor_host_pkg::OP_PROGRAM, 21'h000200, 16'h0F0F, 1000);
    check("stuck poll timeout", 16'h0001, {15'h0000, gotTo});
    $display("test timeout done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    testId();
    testProgram();
    testErase();
    testTimeout();
    report_and_stop();
  end
endmodule
